// ---- sdm_params.svh ----
// Purpose: Register indices, field positions, reset values and timing counts of the SPI DMA engine.
// Assumes: Byte address of a register is four times its index.
// Notes: Definitions only.
`ifndef SDM_PARAMS_SVH
`define SDM_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define SDM_IDX_BYTE_COUNT 12'hF80
`define SDM_IDX_TX_PTR 12'hF81
`define SDM_IDX_RX_PTR 12'hF82
`define SDM_IDX_STATUS 12'hF83
`define SDM_IDX_CTRL2 12'hF86
`define SDM_IDX_CTRL1 12'hF88

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SDM_C1_START 0
`define SDM_C1_DLYINT 1
`define SDM_C1_DUPLEX_LO 2
`define SDM_C1_RXADV 4
`define SDM_C1_TXADV 5
`define SDM_C2_WM_LO 0
`define SDM_C2_DLY_LO 4
`define SDM_ST_IRQ 0
`define SDM_ST_BUSY 1
`define SDM_CTRL_RESET 8'h00
`define SDM_BC_RESET 10'h000
`define SDM_PTR_RESET 12'h000

// ----------------------------------------------------------------------------
// Modes and memory map
// ----------------------------------------------------------------------------
`define SDM_DUPLEX_FULL 2'h2
`define SDM_DUPLEX_TX 2'h1
`define SDM_DUPLEX_RX 2'h0
`define SDM_CLKDIV_4 2'h0
`define SDM_CLKDIV_16 2'h1
`define SDM_SFR_BANK_FIRST 4'hE

// ----------------------------------------------------------------------------
// Timing in instruction cycles (one cycle of hclk)
// ----------------------------------------------------------------------------
`define SDM_MIN_GAP_DIV4 12'h008
`define SDM_MIN_GAP_DIV16 12'h009
`define SDM_MIN_GAP_DIV64 12'h00F
`define SDM_DLYINT_EXTRA 12'h001
`define SDM_PIPE_CYCLES 12'h004

`endif

// ---- sdm_pkg.sv ----
// Purpose: Types shared by the SPI DMA engine.
// Assumes: Constants come from sdm_params.svh.
// Notes: One-hot sequencer states.
package sdm_pkg;

  typedef enum logic [5:0] {
    SDM_ST_IDLE  = 6'h01,
    SDM_ST_GAP   = 6'h02,
    SDM_ST_FETCH = 6'h04,
    SDM_ST_LOAD  = 6'h08,
    SDM_ST_PUSH  = 6'h10,
    SDM_ST_WAIT  = 6'h20
  } sdm_state_e;

endpackage

// ---- sdm_spi_dma.sv ----
// Purpose: SPI DMA engine: delay and timeout control, watermark interrupt, byte counter, pointers.
// Assumes: Serial port and memory run on hclk; memory read data is valid the cycle after mem_rd.
// Notes: AHB-Lite slave with zero wait states; registers are one aligned word each.
//
// Functional notes
// - Master mode gap between bytes is at least 8, 9 or 15 cycles per clock divider.
// - Timeout interrupt off: selected delay is added on top of base overhead.
// - Timeout interrupt on: flag rises when delay passes with no byte completing.
// - Timeout interrupt on: extra gap is one cycle plus base overhead.
// - Delay code decodes to 1..256, 384..896 by 128, 1024, 2048 cycles.
// - Watermark code selects remaining byte count at which the flag rises.
// - Byte counter is ten bits, at most 1024 bytes per transaction.
// - Counter decrements after each byte but the last while a transaction is active.
// - After the last byte the start bit clears itself and counter reads zero.
// - Transmit modes read bytes at the transmit pointer and advance it.
// - Engine never reads and writes memory in the same cycle.
// - Receive modes store bytes at the receive pointer and advance it.
// - Memory in the two top banks is never read or written.
// - Outside a transaction the flag rises per byte; inside it follows watermark.
// - Flag rises when the counter shows the watermark reached.
// - Flag rises when the transaction completes and start clears.
// - After clearing, the watermark flag does not rise again until completion or a rewrite above remaining bytes.
// - Rewriting watermark above remaining bytes raises the flag at once.
// - After that, no new flag until rewritten above remaining or completion.
// - Start bit set by software, cleared by engine, reads one in session.
// - Duplex field: 10 full duplex, 01 transmit only, 00 receive only.
// - Transmit pointer advances only while its advance bit is set.
// - Clearing start mid-transfer ends the current byte, then stops all updates.
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps

`include "sdm_params.svh"

module sdm_spi_dma
  import sdm_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic master_mode,
  input wire logic [1:0] clk_div_sel,
  output logic buf_wr,
  output logic [7:0] buf_wdata,
  input wire logic byte_done,
  input wire logic [7:0] byte_rdata,
  output logic mem_rd,
  output logic mem_wr,
  output logic [11:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic serial_port_irq_flag
);

  // --------------------------------------------------------------------------
  // Decoding functions
  // --------------------------------------------------------------------------
  function automatic logic [11:0] dly_cycles(input logic [3:0] code);
    unique case (code)
      4'h0: dly_cycles = 12'h001;
      4'h1: dly_cycles = 12'h002;
      4'h2: dly_cycles = 12'h004;
      4'h3: dly_cycles = 12'h008;
      4'h4: dly_cycles = 12'h010;
      4'h5: dly_cycles = 12'h020;
      4'h6: dly_cycles = 12'h040;
      4'h7: dly_cycles = 12'h080;
      4'h8: dly_cycles = 12'h100;
      4'h9: dly_cycles = 12'h180;
      4'hA: dly_cycles = 12'h200;
      4'hB: dly_cycles = 12'h280;
      4'hC: dly_cycles = 12'h300;
      4'hD: dly_cycles = 12'h380;
      4'hE: dly_cycles = 12'h400;
      4'hF: dly_cycles = 12'h800;
    endcase
  endfunction

  function automatic logic [10:0] wm_bytes(input logic [3:0] code);
    unique case (code)
      4'h0: wm_bytes = 11'h000;
      4'h1: wm_bytes = 11'h001;
      4'h2: wm_bytes = 11'h002;
      4'h3: wm_bytes = 11'h004;
      4'h4: wm_bytes = 11'h008;
      4'h5: wm_bytes = 11'h010;
      4'h6: wm_bytes = 11'h020;
      4'h7: wm_bytes = 11'h040;
      4'h8: wm_bytes = 11'h080;
      4'h9: wm_bytes = 11'h0C0;
      4'hA: wm_bytes = 11'h100;
      4'hB: wm_bytes = 11'h140;
      4'hC: wm_bytes = 11'h180;
      4'hD: wm_bytes = 11'h1C0;
      4'hE: wm_bytes = 11'h200;
      4'hF: wm_bytes = 11'h240;
    endcase
  endfunction

  function automatic logic [11:0] min_gap(input logic [1:0] sel);
    if (sel == `SDM_CLKDIV_4) begin
      min_gap = `SDM_MIN_GAP_DIV4;
    end else if (sel == `SDM_CLKDIV_16) begin
      min_gap = `SDM_MIN_GAP_DIV16;
    end else begin
      min_gap = `SDM_MIN_GAP_DIV64;
    end
  endfunction

  function automatic logic in_sfr_bank(input logic [11:0] addr);
    in_sfr_bank = (addr[11:8] >= `SDM_SFR_BANK_FIRST);
  endfunction

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  sdm_state_e state_r;
  logic wr_pend_r;
  logic [11:0] wr_idx_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_word;
  logic start_r, dlyint_r, rx_adv_r, tx_adv_r;
  logic [1:0] duplex_r;
  logic [3:0] delay_cycle_select_r, wm_r;
  logic [9:0] byte_count_r;
  logic [11:0] tx_ptr_r, rx_ptr_r;
  logic [11:0] gap_r, gap_len, dly_len, dly_cnt_r;
  logic [7:0] buf_data_r;
  logic mem_rd_r, mem_wr_r;
  logic [11:0] mem_addr_r;
  logic [7:0] mem_wdata_r;
  logic irq_r, wm_armed_r, dly_run_r;
  logic wr_ctrl1, wr_ctrl2, wr_bc, wr_tx, wr_rx, wr_status;
  logic start_req, byte_xfer, last_xfer, uses_tx, uses_rx;
  logic [10:0] remaining, thr, new_thr;
  logic wm_fire, dly_fire, plain_byte;

  // --------------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  always_comb begin
    rd_word = 32'h0000_0000;
    if (haddr[31:14] == 18'h00000) begin
      unique case (haddr[13:2])
        `SDM_IDX_CTRL1: rd_word = {26'h0000000, tx_adv_r, rx_adv_r, duplex_r, dlyint_r, start_r};
        `SDM_IDX_CTRL2: rd_word = {24'h000000, delay_cycle_select_r, wm_r};
        `SDM_IDX_BYTE_COUNT: rd_word = {22'h000000, byte_count_r};
        `SDM_IDX_TX_PTR: rd_word = {20'h00000, tx_ptr_r};
        `SDM_IDX_RX_PTR: rd_word = {20'h00000, rx_ptr_r};
        `SDM_IDX_STATUS: rd_word = {30'h00000000, state_r != SDM_ST_IDLE, irq_r};
        default: rd_word = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_idx_r <= 12'h000;
      hrdata_r <= 32'h0000_0000;
    end else begin
      wr_pend_r <= hsel && hready && htrans[1] && hwrite && (haddr[31:14] == 18'h00000);
      if (hsel && hready && htrans[1]) begin
        wr_idx_r <= haddr[13:2];
        hrdata_r <= hwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  assign wr_ctrl1 = wr_pend_r && (wr_idx_r == `SDM_IDX_CTRL1);
  assign wr_ctrl2 = wr_pend_r && (wr_idx_r == `SDM_IDX_CTRL2);
  assign wr_bc = wr_pend_r && (wr_idx_r == `SDM_IDX_BYTE_COUNT);
  assign wr_tx = wr_pend_r && (wr_idx_r == `SDM_IDX_TX_PTR);
  assign wr_rx = wr_pend_r && (wr_idx_r == `SDM_IDX_RX_PTR);
  assign wr_status = wr_pend_r && (wr_idx_r == `SDM_IDX_STATUS);

  // --------------------------------------------------------------------------
  // Control fields
  // --------------------------------------------------------------------------
  assign start_req = wr_ctrl1 && hwdata[`SDM_C1_START] && (state_r == SDM_ST_IDLE) && !start_r;
  assign byte_xfer = (state_r == SDM_ST_WAIT) && byte_done && start_r;
  assign last_xfer = byte_xfer && (byte_count_r == 10'h000);
  assign uses_tx = (duplex_r == `SDM_DUPLEX_FULL) || (duplex_r == `SDM_DUPLEX_TX);
  assign uses_rx = (duplex_r == `SDM_DUPLEX_FULL) || (duplex_r == `SDM_DUPLEX_RX);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      start_r <= 1'b0;
    end else if (last_xfer) begin
      start_r <= 1'b0;
    end else if (wr_ctrl1) begin
      start_r <= hwdata[`SDM_C1_START] && (start_r || state_r == SDM_ST_IDLE);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {tx_adv_r, rx_adv_r, duplex_r, dlyint_r} <= 5'(`SDM_CTRL_RESET >> 1);
    end else if (wr_ctrl1) begin
      dlyint_r <= hwdata[`SDM_C1_DLYINT];
      duplex_r <= hwdata[`SDM_C1_DUPLEX_LO +: 2];
      rx_adv_r <= hwdata[`SDM_C1_RXADV];
      tx_adv_r <= hwdata[`SDM_C1_TXADV];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {delay_cycle_select_r, wm_r} <= `SDM_CTRL_RESET;
    end else if (wr_ctrl2) begin
      delay_cycle_select_r <= hwdata[`SDM_C2_DLY_LO +: 4];
      wm_r <= hwdata[`SDM_C2_WM_LO +: 4];
    end
  end

  // --------------------------------------------------------------------------
  // Byte counter and pointers
  // --------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      byte_count_r <= `SDM_BC_RESET;
    end else if (wr_bc) begin
      byte_count_r <= hwdata[9:0];
    end else if (byte_xfer && !last_xfer) begin
      byte_count_r <= byte_count_r - 10'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_ptr_r <= `SDM_PTR_RESET;
    end else if (wr_tx) begin
      tx_ptr_r <= hwdata[11:0];
    end else if (byte_xfer && uses_tx && tx_adv_r) begin
      tx_ptr_r <= tx_ptr_r + 12'h001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_ptr_r <= `SDM_PTR_RESET;
    end else if (wr_rx) begin
      rx_ptr_r <= hwdata[11:0];
    end else if (byte_xfer && uses_rx && rx_adv_r) begin
      rx_ptr_r <= rx_ptr_r + 12'h001;
    end
  end

  // --------------------------------------------------------------------------
  // Byte sequencer
  // --------------------------------------------------------------------------
  assign dly_len = dly_cycles(delay_cycle_select_r);
  // Gap counts from the completing byte to the next buffer write, pipeline included.
  assign gap_len = master_mode ? (min_gap(clk_div_sel) - `SDM_DLYINT_EXTRA + (dlyint_r ? `SDM_DLYINT_EXTRA : dly_len)
                                  - `SDM_PIPE_CYCLES) : 12'h000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= SDM_ST_IDLE;
      gap_r <= 12'h000;
    end else begin
      unique case (state_r)
        SDM_ST_IDLE: begin
          if (start_req) begin
            state_r <= SDM_ST_GAP;
            gap_r <= 12'h000;
          end
        end
        SDM_ST_GAP: begin
          if (!start_r) begin
            state_r <= SDM_ST_IDLE;
          end else if (gap_r == 12'h000) begin
            state_r <= SDM_ST_FETCH;
          end else begin
            gap_r <= gap_r - 12'h001;
          end
        end
        SDM_ST_FETCH: begin
          state_r <= start_r ? SDM_ST_LOAD : SDM_ST_IDLE;
        end
        SDM_ST_LOAD: begin
          state_r <= start_r ? SDM_ST_PUSH : SDM_ST_IDLE;
        end
        SDM_ST_PUSH: begin
          state_r <= start_r ? SDM_ST_WAIT : SDM_ST_IDLE;
        end
        SDM_ST_WAIT: begin
          if (byte_done) begin
            if (!start_r || last_xfer) begin
              state_r <= SDM_ST_IDLE;
            end else begin
              state_r <= SDM_ST_GAP;
              gap_r <= gap_len;
            end
          end
        end
      endcase
    end
  end

  assign buf_wr = (state_r == SDM_ST_PUSH) && start_r;
  assign buf_wdata = buf_data_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_data_r <= 8'h00;
    end else if (state_r == SDM_ST_LOAD) begin
      // The read strobe has already dropped here, so the same condition that raised it is used again.
      buf_data_r <= (uses_tx && !in_sfr_bank(tx_ptr_r)) ? mem_rdata : 8'h00;
    end
  end

  // --------------------------------------------------------------------------
  // Memory port
  // --------------------------------------------------------------------------
  assign mem_rd = mem_rd_r;
  assign mem_wr = mem_wr_r;
  assign mem_addr = mem_addr_r;
  assign mem_wdata = mem_wdata_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_rd_r <= 1'b0;
      mem_wr_r <= 1'b0;
      mem_addr_r <= 12'h000;
      mem_wdata_r <= 8'h00;
    end else begin
      mem_rd_r <= (state_r == SDM_ST_GAP) && start_r && (gap_r == 12'h000) && uses_tx
                  && !in_sfr_bank(tx_ptr_r);
      mem_wr_r <= byte_xfer && uses_rx && !in_sfr_bank(rx_ptr_r);
      if ((state_r == SDM_ST_GAP) && (gap_r == 12'h000)) begin
        mem_addr_r <= tx_ptr_r;
      end else if (byte_xfer) begin
        mem_addr_r <= rx_ptr_r;
        mem_wdata_r <= byte_rdata;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Serial port interrupt flag
  // --------------------------------------------------------------------------
  assign remaining = {1'b0, byte_count_r} + 11'h001;
  assign thr = wm_bytes(wm_r);
  assign new_thr = wm_bytes(hwdata[`SDM_C2_WM_LO +: 4]);
  assign wm_fire = start_r && wm_armed_r && (thr != 11'h000) && (remaining <= thr);
  assign dly_fire = start_r && dlyint_r && dly_run_r && !byte_done && (dly_cnt_r + 12'h001 == dly_len);
  assign plain_byte = byte_done && !start_r && (state_r == SDM_ST_IDLE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wm_armed_r <= 1'b0;
    end else if (start_req) begin
      wm_armed_r <= 1'b1;
    end else if (wr_ctrl2 && start_r && (new_thr > remaining)) begin
      wm_armed_r <= 1'b1;
    end else if (wm_fire) begin
      wm_armed_r <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_run_r <= 1'b0;
      dly_cnt_r <= 12'h000;
    end else if (!start_r || !dlyint_r) begin
      dly_run_r <= 1'b0;
      dly_cnt_r <= 12'h000;
    end else if (byte_done) begin
      dly_run_r <= 1'b1;
      dly_cnt_r <= 12'h000;
    end else if (dly_fire) begin
      dly_run_r <= 1'b0;
    end else if (dly_run_r) begin
      dly_cnt_r <= dly_cnt_r + 12'h001;
    end
  end

  // Hardware set wins over a software clear in the same cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'b0;
    end else if (wm_fire || last_xfer || dly_fire || plain_byte) begin
      irq_r <= 1'b1;
    end else if (wr_status && hwdata[`SDM_ST_IRQ]) begin
      irq_r <= 1'b0;
    end
  end

  assign serial_port_irq_flag = irq_r;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  logic [11:0] since_done_r;
  logic after_byte_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      since_done_r <= 12'h000;
      after_byte_r <= 1'b0;
    end else begin
      since_done_r <= byte_done ? 12'h000 : (since_done_r == 12'hFFF ? since_done_r : since_done_r + 12'h001);
      after_byte_r <= start_req ? 1'b0 : (byte_xfer ? 1'b1 : after_byte_r);
    end
  end

  property p_gap_fast;
    @(posedge hclk) disable iff (!hresetn)
      buf_wr && master_mode && dlyint_r && after_byte_r |-> since_done_r + 12'h001 == min_gap(clk_div_sel);
  endproperty
  a_gap_fast: assert property (p_gap_fast) else $error("gap with timeout interrupt wrong");

  property p_gap_delay;
    @(posedge hclk) disable iff (!hresetn)
      buf_wr && master_mode && !dlyint_r && after_byte_r
      |-> since_done_r + 12'h002 == min_gap(clk_div_sel) + dly_len;
  endproperty
  a_gap_delay: assert property (p_gap_delay) else $error("added delay gap wrong");

  property p_timeout;
    @(posedge hclk) disable iff (!hresetn)
      dly_fire |-> (since_done_r + 12'h001 == dly_len) ##1 irq_r;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout flag wrong");

  property p_count_dec;
    @(posedge hclk) disable iff (!hresetn)
      byte_xfer && !last_xfer && !wr_bc |=> byte_count_r == $past(byte_count_r) - 10'h001;
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("counter did not decrement");

  property p_complete;
    @(posedge hclk) disable iff (!hresetn)
      last_xfer |=> !start_r && (byte_count_r == 10'h000) && (state_r == SDM_ST_IDLE) && irq_r;
  endproperty
  a_complete: assert property (p_complete) else $error("completion wrong");

  property p_mem_safe;
    @(posedge hclk) disable iff (!hresetn)
      (mem_rd || mem_wr) |-> !in_sfr_bank(mem_addr) && !(mem_rd && mem_wr);
  endproperty
  a_mem_safe: assert property (p_mem_safe) else $error("forbidden memory access");

  property p_wm_flag;
    @(posedge hclk) disable iff (!hresetn)
      start_r && wm_armed_r && (thr != 11'h000) && (remaining == thr) |=> irq_r && !wm_armed_r;
  endproperty
  a_wm_flag: assert property (p_wm_flag) else $error("watermark flag missed");

  property p_no_rearm;
    @(posedge hclk) disable iff (!hresetn)
      start_r && !wm_armed_r && !wr_ctrl2 && !start_req |=> !wm_armed_r;
  endproperty
  a_no_rearm: assert property (p_no_rearm) else $error("watermark rearmed");

  property p_abort;
    @(posedge hclk) disable iff (!hresetn)
      !start_r && (state_r == SDM_ST_WAIT) && byte_done |=> (state_r == SDM_ST_IDLE) && !mem_wr && !buf_wr;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not stop");

  c_complete: cover property (@(posedge hclk) disable iff (!hresetn) last_xfer);
  c_wm_fire: cover property (@(posedge hclk) disable iff (!hresetn) wm_fire && start_r ##1 start_r);
  c_timeout: cover property (@(posedge hclk) disable iff (!hresetn) dly_fire);
  c_abort: cover property (@(posedge hclk) disable iff (!hresetn) !start_r && state_r == SDM_ST_WAIT && byte_done);

endmodule

// ---- sdm_spi_peer.sv ----
// Purpose: Serial device on the far side of the DMA engine.
// Assumes: A byte takes lat cycles of hclk.
// Notes: Each byte comes back inverted.
`timescale 1ns/1ps
module sdm_spi_peer (
  input logic hclk,
  input logic hresetn,
  input logic [15:0] lat,
  input logic buf_wr,
  input logic [7:0] buf_wdata,
  output logic byte_done,
  output logic [7:0] byte_rdata,
  output logic [7:0] last,
  output logic [15:0] gap
);
  logic [15:0] cd;
  logic [15:0] since;
  // ----
  // Byte timing
  // ----
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cd <= 16'h0000;
      since <= 16'h0000;
      byte_done <= 1'b0;
    end else begin
      cd <= buf_wr ? lat : cd - {15'h0000, cd != 16'h0000};
      byte_done <= cd == 16'h0001;
      since <= byte_done ? 16'h0001 : since + 16'h0001;
      if (buf_wr) last <= buf_wdata;
      if (buf_wr) gap <= since;
    end
  end
  // Between bytes the data line changes every cycle.
  assign byte_rdata = byte_done ? ~last : since[7:0];
endmodule

// ---- test_sdm_spi_dma.sv ----
// Purpose: Self-checking bench of the SPI DMA engine.
// Assumes: Master mode; memory answers the cycle after a read strobe.
// Notes: The peer byte time is 10 cycles, and 60 from the watermark test on.
`timescale 1ns/1ps
module test_sdm_spi_dma;
  localparam logic [31:0] a_bc = 32'h3E00;
  localparam logic [31:0] a_tx = 32'h3E04;
  localparam logic [31:0] a_st = 32'h3E0C;
  localparam logic [31:0] a_c2 = 32'h3E18;
  localparam logic [31:0] a_c1 = 32'h3E20;
  localparam int th [16] = '{0, 1, 2, 4, 8, 16, 32, 64, 128, 192, 256, 320, 384, 448, 512, 576};
  logic hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0, clk_div_sel = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
  logic [15:0] lat = 16'h000A, gap;
  logic [7:0] mem_rdata = 8'h00, buf_wdata, byte_rdata, mem_wdata, last;
  logic [7:0] mem [0:4095];
  logic [11:0] mem_addr;
  logic hreadyout, hresp, buf_wr, byte_done, mem_rd, mem_wr, serial_port_irq_flag;
  int err_count = 0;
  int checks_done = 0;
  sdm_spi_dma dut_u (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .master_mode(1'b1), .clk_div_sel, .buf_wr, .buf_wdata,
    .byte_done, .byte_rdata, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata, .serial_port_irq_flag);
  sdm_spi_peer peer_u (.hclk, .hresetn, .lat, .buf_wr, .buf_wdata, .byte_done, .byte_rdata, .last, .gap);
  initial forever #50 hclk = ~hclk;
  always @(posedge hclk) begin
    if (mem_rd) mem_rdata <= mem[mem_addr];
    if (mem_wr) mem[mem_addr] <= mem_wdata;
  end
  task automatic end_sim();
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) $display("Error at %0t: got %h expected %h", $time, got, exp);
    if (got !== exp) err_count++;
  endtask
  task automatic stuck();
    err_count++;
    $display("Error at %0t: wait timed out", $time);
    end_sim();
  endtask
  task automatic hold();
    for (int n = 0; n < 64; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) return;
    end
    stuck();
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    hold();
    htrans <= 2'h0;
    hwdata <= d;
    hold();
    q = hrdata;
  endtask
  // Waits for the flag, or with busy set polls the status until the engine is idle.
  task automatic wt(input logic busy);
    for (int n = 0; n < 3000; n++) begin
      if (busy) bus(a_st, 1'b0, 32'h0);
      else @(posedge hclk);
      if (busy ? q[1] === 1'b0 : serial_port_irq_flag === 1'b1) return;
    end
    stuck();
  endtask
  task automatic run(input logic [7:0] c2, input logic [7:0] c1, input logic [9:0] bc, input logic [11:0] rx);
    bus(a_st, 1'b1, 32'h1);
    bus(a_c2, 1'b1, {24'h0, c2});
    bus(a_bc, 1'b1, {22'h0, bc});
    bus(a_tx, 1'b1, 32'h100);
    bus(32'h3E08, 1'b1, {20'h0, rx});
    bus(a_c1, 1'b1, {24'h0, c1});
  endtask
  function automatic int gp(input int k);
    if (k > 15) return k == 16 ? 8 : k == 17 ? 9 : 15;
    return 7 + (k <= 8 ? 1 << k : k <= 13 ? 128 * (k - 6) : 1024 * (k - 13));
  endfunction
  initial begin
    for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'hA5;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(a_c2, 1'b0, 32'h0);
    chk(q, 32'h0);
    bus(32'h3E10, 1'b1, 32'hFF);
    bus(32'h3E10, 1'b0, 32'h0);
    chk(q, 32'h0);
    run(8'h00, 8'h39, 10'h002, 12'h200);
    bus(a_c1, 1'b0, 32'h0);
    chk(q, 32'h39);
    wt(1'b0);
    bus(a_bc, 1'b0, 32'h0);
    chk(q, 32'h0);
    bus(a_c1, 1'b0, 32'h0);
    chk(q, 32'h38);
    bus(a_tx, 1'b0, 32'h0);
    chk(q, 32'h103);
    for (int i = 0; i < 3; i++) begin
      chk({24'h0, mem[12'h200 + i]}, {24'h0, ~mem[12'h100 + i]});
      chk({24'h0, mem[12'h100 + i]}, {24'h0, 8'(i) ^ 8'hA5});
    end
    $display("Test duplex done");
    for (int k = 0; k < 19; k++) begin
      clk_div_sel <= k < 16 ? 2'h0 : 2'(k - 16);
      run(k < 16 ? {4'(k), 4'h0} : 8'hF0, k < 16 ? 8'h05 : 8'h07, 10'h001, 12'h200);
      wt(1'b0);
      chk({16'h0, gap}, 32'(gp(k)));
      chk({24'h0, last}, {24'h0, mem[12'h100]});
      bus(a_tx, 1'b0, 32'h0);
      chk(q, 32'h100);
    end
    $display("Test gaps done");
    lat <= 16'h003C;
    for (int c = 0; c < 16; c++) begin
      for (int r = 0; r < 2; r++) begin
        if (c == 0 && r == 1) continue;
        run({4'hF, 4'(c)}, 8'h09, 10'(th[c] - r), 12'h200);
        bus(a_c1, 1'b0, 32'h0);
        chk(q, 32'h09);
        bus(a_st, 1'b0, 32'h0);
        chk({31'h0, q[0]}, {31'h0, r == 1});
        if (r == 0) begin
          bus(a_c2, 1'b1, 32'hFF);
          @(posedge hclk);
          bus(a_st, 1'b0, 32'h0);
          chk({31'h0, q[0]}, {31'h0, c != 15});
          bus(a_st, 1'b1, 32'h1);
          bus(a_st, 1'b0, 32'h0);
          chk({31'h0, q[0]}, 32'h0);
        end
        bus(a_c1, 1'b1, 32'h08);
        wt(1'b1);
        bus(a_bc, 1'b0, 32'h0);
        chk(q, 32'(th[c] - r));
      end
    end
    $display("Test watermark done");
    run(8'h30, 8'h03, 10'h001, 12'h200);
    wt(1'b0);
    bus(a_c1, 1'b0, 32'h0);
    chk(q, 32'h03);
    wt(1'b1);
    bus(a_bc, 1'b0, 32'h0);
    chk(q, 32'h0);
    $display("Test timeout done");
    run(8'h00, 8'h01, 10'h000, 12'hE00);
    wt(1'b0);
    chk({24'h0, mem[12'hE00]}, 32'hA5);
    $display("Test banks done");
    end_sim();
  end
endmodule
